// File: include/dimr_pkg.sv
// shared constants and types for the sdram init and mode register block
package dimr_pkg;
    // clock and timing
    localparam int XPR_TCK = 5; // reset exit floor in clocks
    localparam int MRD_CYC = 4; // mode set cycle time, clocks
    localparam int MOD_CYC = 12; // mode update delay, clocks
    localparam int DLLK_CYC = 512; // dll lock time, clocks
    localparam int ZQINIT_CYC = 512; // initial calibration time, clocks
    localparam int CNT_W = 10; // width of the wait counters
    // axi register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MR0 = 8'h08;
    localparam logic [7:0] OFS_MR1 = 8'h0c;
    localparam logic [7:0] OFS_MR2 = 8'h10;
    localparam logic [7:0] OFS_MR3 = 8'h14;
    localparam logic [7:0] OFS_LAT = 8'h18;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    // status field positions
    localparam int ST_READY_BIT = 4;
    localparam int ST_ERR_LSB = 8;
    localparam int NUM_ERR = 4;
    localparam int ERR_ORDER = 0; // init mode set out of order
    localparam int ERR_MRD = 1; // mode sets too close
    localparam int ERR_MOD = 2; // command inside update delay
    localparam int ERR_BUSY = 3; // read dropped while one pending
    // bank select codes
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    localparam logic [2:0] BA_MR3 = 3'h3;
    // mode register fields and command address bits
    localparam int A_BT = 3; // burst type bit
    localparam int A_DLLRST = 8; // dll reset request
    localparam int A_CHOP = 12; // burst chop select on commands
    localparam int A_ZQLONG = 10; // long calibration when high
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam logic [4:0] CL_BASE = 5'h04; // cas latency offset for code
    localparam logic [4:0] CL_EXT = 5'h08; // added when the low cl bit set
    localparam logic [1:0] AL_MINUS1 = 2'h1;
    localparam logic [1:0] AL_MINUS2 = 2'h2;
    // burst beat points
    localparam logic [2:0] BEAT_LAST = 3'h7;
    localparam logic [2:0] BEAT_HALF = 3'h4;
    localparam logic [2:0] WINT_FULL = 3'h7; // internal write point, eight beats
    localparam logic [2:0] WINT_CHOP = 3'h5; // two clocks earlier, fixed chop

    // command pins as one carrier
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [13:0] addr;
    } dimr_cmd_t;

    // initialization progress
    typedef enum logic [2:0] {
        INIT_RST, INIT_WAIT_CKE, INIT_XPR, INIT_CFG, INIT_CAL, INIT_READY
    } dimr_state_t;
endpackage : dimr_pkg

// File: rtl/dimr_burst.sv
// burst column sequencer for reads and writes
`timescale 1ns/1ps
`default_nettype none
module dimr_burst (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // burst request
    input wire logic start,
    input wire logic is_read,
    input wire logic [2:0] col_start,
    input wire logic chop,
    input wire logic interleave,
    input wire logic fixed_chop,
    // beat outputs
    output logic [2:0] beat_col_r,
    output logic beat_valid_r,
    output logic drive_n_r,
    output logic take_r,
    output logic int_write_r
);
    import dimr_pkg::*;

    logic busy_r; // burst in progress
    logic [2:0] cnt_r; // beat index
    logic rd_r; // latched direction
    logic chop_r; // latched chop
    logic il_r; // latched interleave
    logic fix_r; // latched fixed chop
    logic [2:0] c_r; // latched start column
    logic [2:0] col_nxt;

    // column for the current beat
    always_comb begin
        if (!rd_r) begin
            // low start bits ignored on writes
            col_nxt = chop_r ? {c_r[2], cnt_r[1:0]} : cnt_r;
        end else if (il_r) begin
            col_nxt = c_r ^ cnt_r;
        end else begin
            // wrap in the half, then the other half
            col_nxt = {c_r[2] ^ cnt_r[2], c_r[1:0] + cnt_r[1:0]};
        end
    end

    // beat counter and latched request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
            cnt_r <= 3'h0;
            rd_r <= 1'b0;
            chop_r <= 1'b0;
            il_r <= 1'b0;
            fix_r <= 1'b0;
            c_r <= 3'h0;
        end else if (start && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r <= 3'h0;
            rd_r <= is_read;
            chop_r <= chop;
            il_r <= interleave;
            fix_r <= fixed_chop;
            c_r <= col_start;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == BEAT_LAST) begin
                busy_r <= 1'b0;
            end
        end
    end

    // registered beat outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            beat_col_r <= 3'h0;
            beat_valid_r <= 1'b0;
            drive_n_r <= 1'b1;
            take_r <= 1'b0;
            int_write_r <= 1'b0;
        end else begin
            beat_col_r <= col_nxt;
            beat_valid_r <= busy_r;
            // chop read: last four slots stay high impedance
            drive_n_r <= !(busy_r && rd_r && !(chop_r && cnt_r >= BEAT_HALF));
            // chop write: last four beats ignored
            take_r <= busy_r && !rd_r && !(chop_r && cnt_r >= BEAT_HALF);
            // fixed chop pulls the internal write in by two
            int_write_r <= busy_r && !rd_r && (cnt_r == (fix_r ? WINT_CHOP : WINT_FULL));
        end
    end
endmodule : dimr_burst
`default_nettype wire

// File: rtl/dimr_top.sv
// sdram device init tracking, mode registers and axi4-lite view
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - termination off in reset until clock enable high
// - bank bits select the mode register
// - mode update delay before other commands
// - bit three picks sequential or interleaved
// - low bits pick chop, eight or on-the-fly
// - read column order sequential or interleaved
// - chop read drives four beats, then hiz
// - writes ignore low column bits
// - fixed chop internal write two clocks earlier
// - whole clock cas latency, read latency sum
module dimr_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // memory pins from the controller
    input wire logic mem_reset_n,
    input wire logic mem_cke,
    input wire logic termination_control_input,
    input wire dimr_pkg::dimr_cmd_t mem_cmd,
    // termination, beat and ready outputs
    output logic term_on_r,
    output logic term_hiz_r,
    output logic [2:0] beat_col_r,
    output logic beat_valid_r,
    output logic dq_oe_n_r,
    output logic wr_take_r,
    output logic int_write_r,
    output logic init_ready_r,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import dimr_pkg::*;

    localparam logic [CNT_W-1:0] XPR_N = CNT_W'(XPR_TCK); // one tck per aclk
    localparam logic [CNT_W-1:0] MRD_N = CNT_W'(MRD_CYC);
    localparam logic [CNT_W-1:0] MOD_N = CNT_W'(MOD_CYC);
    localparam logic [CNT_W-1:0] CAL_N =
        CNT_W'((DLLK_CYC > ZQINIT_CYC) ? DLLK_CYC : ZQINIT_CYC);

    // pin synchronisers, first stage feeds only the second
    logic rst_s1_r, rst_s2_r;
    logic cke_s1_r, cke_s2_r;
    logic odt_s1_r, odt_s2_r;
    dimr_cmd_t cmd_s1_r, cmd_s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
            cke_s1_r <= 1'b0;
            cke_s2_r <= 1'b0;
            odt_s1_r <= 1'b0;
            odt_s2_r <= 1'b0;
            cmd_s1_r <= '1;
            cmd_s2_r <= '1;
        end else begin
            rst_s1_r <= mem_reset_n;
            rst_s2_r <= rst_s1_r;
            cke_s1_r <= mem_cke;
            cke_s2_r <= cke_s1_r;
            odt_s1_r <= termination_control_input;
            odt_s2_r <= odt_s1_r;
            cmd_s1_r <= mem_cmd;
            cmd_s2_r <= cmd_s1_r;
        end
    end

    // command decode, only while clock enable is high
    logic cmd_en;
    logic is_mrs, is_rd, is_wr, is_zq, is_other;
    logic [31:0] ctrl_r; // bit0 accepts pin commands
    assign cmd_en = rst_s2_r && cke_s2_r && ctrl_r[0];
    assign is_mrs = cmd_en && cmd_s2_r[20:17] == 4'h0;
    assign is_rd = cmd_en && cmd_s2_r[20:17] == 4'h5;
    assign is_wr = cmd_en && cmd_s2_r[20:17] == 4'h4;
    assign is_zq = cmd_en && cmd_s2_r[20:17] == 4'h6 && cmd_s2_r.addr[A_ZQLONG];
    // any selected non-nop other than a mode set counts as a command
    assign is_other = cmd_en && !cmd_s2_r.cs_n && cmd_s2_r[19:17] != 3'h7 && !is_mrs;

    // init state and its wait counter
    dimr_state_t state_r;
    logic [CNT_W-1:0] wait_r; // clocks left in the current wait
    logic [1:0] order_r; // init mode sets seen so far

    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_s2_r) begin
            state_r <= INIT_RST;
            wait_r <= '0;
            order_r <= 2'h0;
        end else begin
            if (wait_r != '0) begin
                wait_r <= wait_r - CNT_W'(1);
            end
            unique case (state_r)
                INIT_RST: state_r <= INIT_WAIT_CKE;
                INIT_WAIT_CKE: begin
                    // clock enable sampled high starts the exit wait
                    if (cke_s2_r) begin
                        state_r <= INIT_XPR;
                        wait_r <= XPR_N;
                    end
                end
                INIT_XPR: begin
                    if (wait_r == '0) begin
                        state_r <= INIT_CFG;
                    end
                end
                INIT_CFG: begin
                    if (is_mrs) begin
                        order_r <= order_r + 2'h1;
                    end
                    // long calibration arms lock wait, whatever the count of sets seen
                    if (is_zq) begin
                        state_r <= INIT_CAL;
                        wait_r <= CAL_N;
                    end
                end
                INIT_CAL: begin
                    if (wait_r == '0) begin
                        state_r <= INIT_READY;
                    end
                end
                INIT_READY: state_r <= INIT_READY;
            endcase
        end
    end

    // ready flag to the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_ready_r <= 1'b0;
        end else begin
            init_ready_r <= rst_s2_r && state_r == INIT_READY;
        end
    end

    // termination: hiz from reset until clock enable seen high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_hiz_r <= 1'b1;
            term_on_r <= 1'b0;
        end else begin
            if (!rst_s2_r) begin
                term_hiz_r <= 1'b1;
            end else if (cke_s2_r) begin
                term_hiz_r <= 1'b0;
            end
            term_on_r <= !term_hiz_r && odt_s2_r;
        end
    end

    // mode registers, cleared in reset since contents are undefined
    logic [13:0] mr_r [4];
    logic [CNT_W-1:0] mrd_r; // clocks since last mode set, saturating
    logic [13:0] mr_wr;
    assign mr_wr = cmd_s2_r.addr;

    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_s2_r) begin
            for (int i = 0; i < 4; i++) begin
                mr_r[i] <= '0;
            end
        end else if (is_mrs && !cmd_s2_r.ba[2]) begin
            // whole word taken, bank bits pick the target
            // update lands at once, well inside the update delay
            mr_r[cmd_s2_r.ba[1:0]] <= mr_wr;
        end else if (mr_r[0][A_DLLRST]) begin
            mr_r[0][A_DLLRST] <= 1'b0; // dll reset bit clears itself
        end
    end

    // spacing counter from the last mode set
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_s2_r) begin
            mrd_r <= MOD_N;
        end else if (is_mrs) begin
            mrd_r <= '0;
        end else if (mrd_r != MOD_N) begin
            mrd_r <= mrd_r + CNT_W'(1);
        end
    end

    // protocol error events seen by the device
    logic [NUM_ERR-1:0] err_set;
    logic [2:0] exp_ba; // bank expected at this point of init
    logic rd_pend_r;
    always_comb begin
        unique case (order_r)
            2'h0: exp_ba = BA_MR2;
            2'h1: exp_ba = BA_MR3;
            2'h2: exp_ba = BA_MR1;
            default: exp_ba = BA_MR0;
        endcase
        err_set = '0;
        err_set[ERR_ORDER] = is_mrs && state_r == INIT_CFG && cmd_s2_r.ba != exp_ba;
        err_set[ERR_MRD] = is_mrs && mrd_r < MRD_N;
        err_set[ERR_MOD] = is_other && mrd_r < MOD_N;
        err_set[ERR_BUSY] = is_rd && rd_pend_r;
    end

    // latency decode from the mode registers
    logic [4:0] cl_val; // cas_latency_value
    logic [4:0] al_val; // additive_latency_value
    logic [5:0] rl_val; // read_latency_value
    always_comb begin
        // whole clocks only, no half steps
        cl_val = CL_BASE + {2'h0, mr_r[0][6:4]} + (mr_r[0][2] ? CL_EXT : 5'h00);
        unique case (mr_r[1][4:3])
            AL_MINUS1: al_val = cl_val - 5'h01;
            AL_MINUS2: al_val = cl_val - 5'h02;
            default: al_val = 5'h00;
        endcase
        rl_val = {1'b0, al_val} + {1'b0, cl_val};
    end

    // burst mode decode
    logic [1:0] bl_mode;
    logic cmd_chop;
    assign bl_mode = mr_r[0][1:0];
    // on-the-fly: address bit low asks for chop
    assign cmd_chop = (bl_mode == BL_FIX4) ||
                      (bl_mode == BL_OTF && !cmd_s2_r.addr[A_CHOP]);

    // read waits its latency before the burst starts
    logic [5:0] rd_wait_r;
    logic [2:0] rd_col_r;
    logic rd_chop_r;
    logic rd_go;
    assign rd_go = rd_pend_r && rd_wait_r == 6'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_s2_r) begin
            rd_pend_r <= 1'b0;
            rd_wait_r <= 6'h0;
            rd_col_r <= 3'h0;
            rd_chop_r <= 1'b0;
        end else if (is_rd && !rd_pend_r) begin
            rd_pend_r <= 1'b1;
            rd_wait_r <= rl_val;
            rd_col_r <= cmd_s2_r.addr[2:0];
            rd_chop_r <= cmd_chop;
        end else if (rd_go) begin
            rd_pend_r <= 1'b0;
        end else if (rd_pend_r) begin
            rd_wait_r <= rd_wait_r - 6'h1;
        end
    end

    // burst engine; reads take priority over a write in the same clock
    logic bstart, bread, bchop;
    logic [2:0] bcol;
    assign bstart = rd_go || is_wr;
    assign bread = rd_go;
    assign bcol = rd_go ? rd_col_r : cmd_s2_r.addr[2:0];
    assign bchop = rd_go ? rd_chop_r : cmd_chop;

    dimr_burst u_burst (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(bstart),
        .is_read(bread),
        .col_start(bcol),
        .chop(bchop),
        .interleave(mr_r[0][A_BT]),
        .fixed_chop(bl_mode == BL_FIX4),
        .beat_col_r(beat_col_r),
        .beat_valid_r(beat_valid_r),
        .drive_n_r(dq_oe_n_r),
        .take_r(wr_take_r),
        .int_write_r(int_write_r)
    );

    // axi4-lite write side
    logic aw_have_r, w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [NUM_ERR-1:0] err_r; // sticky, write one to clear
    logic wr_fire;
    logic wr_hit;
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_hit = aw_addr_r == OFS_CTRL || aw_addr_r == OFS_STATUS;

    // address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control register, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_fire && aw_addr_r == OFS_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_r[b]) begin
                    ctrl_r[b*8 +: 8] <= w_data_r[b*8 +: 8];
                end
            end
        end
    end

    // sticky errors; a new event beats a clear in the same clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_r <= '0;
        end else begin
            for (int e = 0; e < NUM_ERR; e++) begin
                if (err_set[e]) begin
                    err_r[e] <= 1'b1;
                end else if (wr_fire && aw_addr_r == OFS_STATUS && w_strb_r[1] &&
                             w_data_r[ST_ERR_LSB + e]) begin
                    err_r[e] <= 1'b0;
                end
            end
        end
    end

    // read data mux
    logic [31:0] rd_data;
    logic rd_hit;
    always_comb begin
        rd_data = 32'h0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rd_data = ctrl_r;
            OFS_STATUS: begin
                rd_data[2:0] = state_r;
                rd_data[ST_READY_BIT] = init_ready_r;
                rd_data[ST_ERR_LSB +: NUM_ERR] = err_r;
            end
            OFS_MR0: rd_data[13:0] = mr_r[0];
            OFS_MR1: rd_data[13:0] = mr_r[1];
            OFS_MR2: rd_data[13:0] = mr_r[2];
            OFS_MR3: rd_data[13:0] = mr_r[3];
            OFS_LAT: rd_data[21:0] = {rl_val, 3'h0, al_val, 3'h0, cl_val};
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel, one transfer at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule : dimr_top
`default_nettype wire

// File: tb/dimr_top_properties.sv
// port assertions for the sdram init and mode register block
`timescale 1ns/1ps
`default_nettype none
module dimr_top_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched pins
    input wire logic mem_cke,
    input wire logic term_on_r,
    input wire logic term_hiz_r,
    input wire logic beat_valid_r,
    input wire logic dq_oe_n_r,
    input wire logic wr_take_r,
    input wire logic int_write_r
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // eight beat slots, and the silent tail of a chop
    sequence s_eight; beat_valid_r[*8]; endsequence
    sequence s_tail; (beat_valid_r && dq_oe_n_r)[*4]; endsequence
    property p_hiz; term_hiz_r && !mem_cke |=> term_hiz_r; endproperty
    a_hiz: assert property (p_hiz) else $error("hiz left early");
    property p_on; term_on_r |-> !term_hiz_r; endproperty
    a_on: assert property (p_on) else $error("on while hiz");
    property p_len; $rose(beat_valid_r) |-> s_eight; endproperty
    a_len: assert property (p_len) else $error("burst not eight");
    property p_chop; $rose(dq_oe_n_r) && beat_valid_r |-> s_tail; endproperty
    a_chop: assert property (p_chop) else $error("chop tail driven");
    property p_oe; !dq_oe_n_r |-> beat_valid_r && !wr_take_r; endproperty
    a_oe: assert property (p_oe) else $error("drive off slot");
    property p_take; $rose(wr_take_r) |-> $rose(beat_valid_r); endproperty
    a_take: assert property (p_take) else $error("take late");
    property p_iw; int_write_r |-> beat_valid_r ##1 !int_write_r; endproperty
    a_iw: assert property (p_iw) else $error("write point");
    property p_end; int_write_r |-> ##[1:3] !beat_valid_r; endproperty
    a_end: assert property (p_end) else $error("write point early");
endmodule : dimr_top_properties
`default_nettype wire

// File: tb/dimr_ctrl_model.sv
// controller model driving the memory reset, clock enable and command pins
`timescale 1ns/1ps
`default_nettype none
module dimr_ctrl_model #(
    parameter int CKE_WAIT = 50000 // clocks from reset release to clock enable
) (
    // clock in, memory pins out
    input wire logic aclk,
    output logic mem_reset_n,
    output logic mem_cke,
    output dimr_pkg::dimr_cmd_t mem_cmd
);
    import dimr_pkg::*;
    // reset and clock enable low, deselected, at power up
    initial {mem_reset_n, mem_cke, mem_cmd} = {2'h0, 21'h1fffff};
    // one command, then deselects with a changing address
    task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a, int n);
        @(posedge aclk) mem_cmd <= {c, ba, a};
        repeat (n) @(posedge aclk) mem_cmd <= {4'hf, ~mem_cmd.ba, ~mem_cmd.addr};
    endtask : cmd
    // power-up order, each register written whole
    task automatic init(input logic [13:0] mr0, mr2);
        repeat (10) @(posedge aclk); // reset held 100 ns
        mem_reset_n <= 1'b1;
        repeat (CKE_WAIT) @(posedge aclk);
        mem_cke <= 1'b1; // high from here on
        repeat (8) @(posedge aclk); // reset exit time
        cmd(4'h0, BA_MR2, mr2, MRD_CYC);
        cmd(4'h0, BA_MR3, 14'h0, MRD_CYC);
        cmd(4'h0, BA_MR1, 14'h0, MRD_CYC); // dll enabled
        cmd(4'h0, BA_MR0, mr0 | 14'h0100, MOD_CYC);
        cmd(4'h6, 3'h0, 14'h0400, DLLK_CYC + ZQINIT_CYC); // long calibration
    endtask : init
endmodule : dimr_ctrl_model
`default_nettype wire

// File: tb/dimr_top_tb.sv
// self-checking bench for the sdram init and mode register block
`timescale 1ns/1ps
`default_nettype none
module dimr_top_tb;
    import dimr_pkg::*;
    logic aclk, aresetn, mem_reset_n, mem_cke, termination_control_input, term_on_r, term_hiz_r;
    logic beat_valid_r, dq_oe_n_r, wr_take_r, int_write_r, init_ready_r, s_axi_awvalid;
    logic s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0] beat_col_r;
    logic [7:0] s_axi_awaddr, s_axi_araddr, oe, tk, iw;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [13:0] mr0, mr2;
    logic [23:0] cols, ecols;
    logic [4:0] cl;
    dimr_cmd_t mem_cmd;
    int failures, n_compared, cyc;
    dimr_top DUT (.*);
    dimr_ctrl_model #(.CKE_WAIT(20)) M (.aclk, .mem_reset_n, .mem_cke, .mem_cmd);
    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            failures++;
            test_done();
        end
    end
    // axi tasks hold each channel until its ready
    task automatic rd(input logic [7:0] a);
        @(posedge aclk) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk) s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        {r, d} = {s_axi_rresp, s_axi_rdata};
        @(posedge aclk) s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
        do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
        @(posedge aclk) {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(negedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge aclk) s_axi_bready <= 1'b0;
    endtask : wr
    // expected column of beat i
    function automatic logic [2:0] ecol(input logic rd_b, bt, ch, input logic [2:0] c, i);
        if (!rd_b) return ch ? {c[2], i[1:0]} : i;
        return bt ? c ^ i : {c[2] ^ i[2], c[1:0] + i[1:0]};
    endfunction : ecol
    // one burst, every slot recorded
    task automatic burst(input logic is_rd, input logic [2:0] c, input logic a12);
        logic ch;
        ch = mr0[1:0] == BL_FIX4 || (mr0[1:0] == BL_OTF && !a12);
        M.cmd({3'h2, is_rd}, 3'h0, {1'b0, a12, 9'h0, c}, 2);
        do @(negedge aclk); while (!beat_valid_r);
        for (int i = 0; i < 8; i++) begin
            cols[i*3 +: 3] = beat_col_r;
            ecols[i*3 +: 3] = ecol(is_rd, mr0[3], ch, c, 3'(i));
            {oe[i], tk[i], iw[i]} = {dq_oe_n_r, wr_take_r, int_write_r};
            @(negedge aclk);
        end
        chk({8'h0, cols}, {8'h0, ecols});
        chk({24'h0, oe}, is_rd ? (ch ? 32'hf0 : 32'h0) : 32'hff);
        chk({24'h0, tk}, is_rd ? 32'h0 : (ch ? 32'h0f : 32'hff));
        chk({24'h0, iw}, is_rd ? 32'h0 : (mr0[1:0] == BL_FIX4 ? 32'h20 : 32'h80));
    endtask : burst
    initial begin
        {aresetn, termination_control_input, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(47657));
        mr2 = 14'($urandom) & 14'h06ff;
        mr0 = {7'h0, 3'($urandom), 1'b0, 1'($urandom), 2'h0};
        cl = CL_BASE + {2'h0, mr0[6:4]} + (mr0[2] ? CL_EXT : 5'h0);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk) chk(32'(term_hiz_r), 32'h1);
        M.init(mr0, mr2);
        rd(OFS_STATUS);
        chk(d, 32'h15);
        chk(32'(init_ready_r), 32'h1);
        rd(OFS_MR2);
        chk(d, {18'h0, mr2});
        rd(OFS_LAT);
        chk(d, {11'h0, cl, 11'h0, cl});
        rd(8'h20);
        chk({r, d}, 34'h200000000);
        wr(8'h1c, 32'h1);
        chk(32'(r), 32'h2);
        wr(OFS_CTRL, CTRL_RST);
        chk(32'(r), 32'h0);
        termination_control_input <= 1'b1; // low through init, free now
        repeat (5) @(negedge aclk);
        chk(32'(term_on_r), 32'h1);
        for (int k = 0; k < 12; k++) begin
            mr0[3] = k[0];
            mr0[1:0] = 2'(k / 4);
            M.cmd(4'h0, BA_MR0, mr0, MOD_CYC); // idle device
            burst(k[1], 3'($urandom), 1'($urandom));
        end
        rd(OFS_STATUS);
        chk(d, 32'h15);
        test_done();
    end
endmodule : dimr_top_tb
bind dimr_top dimr_top_properties P (.aclk, .aresetn, .mem_cke, .term_on_r, .term_hiz_r,
    .beat_valid_r, .dq_oe_n_r, .wr_take_r, .int_write_r);
`default_nettype wire
